// file: rtl/gpsh_defines.vh
/*
 constants of the gpio pin-sharing block: register indices, control fields,
 pin positions and reset values. assumes the includer uses the macros only.
*/
`ifndef GPSH_DEFINES_VH
`define GPSH_DEFINES_VH

// register indices, byte address is four times the index
`define GPSH_CTRL_IDX     16'hC006
`define GPSH_OUT_IDX      16'hC008
`define GPSH_DIR_IDX      16'hC009
`define GPSH_IN_IDX       16'hC00A
`define GPSH_CLAIM_IDX    16'hC00B

// reset values and masks
`define GPSH_CTRL_RST     16'h0000
`define GPSH_CTRL_MASK    16'h01FF
`define GPSH_OUT_RST      32'h00000000
`define GPSH_PIN_VALID    32'hE1F8FFFF

// control register fields
`define GPSH_F_HOST_EN    0
`define GPSH_F_FSP_EN     1
`define GPSH_F_SPI_EN     2
`define GPSH_F_UART_EN    3
`define GPSH_F_SPI_XM     4
`define GPSH_F_SSI_ALT    5
`define GPSH_F_FSP_XM     6
`define GPSH_F_I2C_EN     7
`define GPSH_F_ID_EN      8

// pin positions
`define GPSH_PIN_I2C_LSB  30
`define GPSH_PIN_ID       29
`define GPSH_PIN_HOST_INT 24
`define GPSH_PIN_HOST_LSB 19
`define GPSH_PIN_SSI_ALT  15
`define GPSH_PIN_FSP_LSB  12
`define GPSH_PIN_SPI_LSB  8
`define GPSH_PIN_SSI_STD  9
`define GPSH_PIN_UART_TX  7
`define GPSH_PIN_UART_RX  6

// idle levels seen by controllers when their pins are not routed, and fast serial pin enables
`define GPSH_HOST_IDLE    5'h1C
`define GPSH_SPI_IDLE     4'h2
`define GPSH_FSP_OE       4'h5

`endif

// file: rtl/gpsh_pin_capture.v
/*
 single-stage capture of raw pin levels into the gpio input register.
 assumes pins may change at any time; metastability is accepted by design.
*/
`timescale 1ns/1ps
`default_nettype none
module gpsh_pin_capture #(
    parameter WIDTH = 32
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // pins in, captured bits out
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] cap_reg
);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cap_reg <= {WIDTH{1'b0}};
        else
            cap_reg <= pin_in;
    end
endmodule // gpsh_pin_capture
`default_nettype wire

// file: rtl/gpsh_pin_drive.v
/*
 output stage of the pins: registers level and enable for each pin.
 assumes reset enables are given per pin by the parent.
*/
`timescale 1ns/1ps
`default_nettype none
module gpsh_pin_drive #(
    parameter WIDTH           = 32,
    parameter [WIDTH-1:0] RST_OE = {WIDTH{1'b0}}
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // next level and enable
    input  wire [WIDTH-1:0] out_next,
    input  wire [WIDTH-1:0] oe_next,
    // pin drive
    output reg  [WIDTH-1:0] out_reg,
    output reg  [WIDTH-1:0] oe_reg
);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_reg <= {WIDTH{1'b0}};
            oe_reg  <= RST_OE;
        end
        else
        begin
            out_reg <= out_next;
            oe_reg  <= oe_next;
        end
    end
endmodule // gpsh_pin_drive
`default_nettype wire

// file: rtl/gpsh_pin_share.v
/*
 gpio pin sharing: routes the 25 gpio pins to the host port, fast serial
 port, spi, uart, eeprom i2c and id pin, with apb register access.
 assumes apb master in the pclk domain and on-chip controllers on pclk.
*/
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "gpsh_defines.vh"
module gpsh_pin_share (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [19:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // gpio pins
    input  wire [31:0] gpio_in,
    output wire [31:0] gpio_out,
    output wire [31:0] gpio_oe,
    // host parallel port controller
    input  wire        host_int,
    input  wire [15:0] host_data_bus_out,
    input  wire        host_data_bus_oe,
    output reg  [15:0] host_data_bus_in,
    output reg  [4:0]  host_ctl_in,
    // fast serial port controller
    input  wire        fast_serial_port_rts,
    input  wire        fast_serial_port_txd,
    output reg         fast_serial_port_cts,
    output reg         fast_serial_port_rxd,
    // fast serial port on external memory port
    input  wire [1:0]  xm_fsp_in,
    output reg  [1:0]  xm_fsp_out,
    // spi controller, order mosi sck select miso
    input  wire [3:0]  spi_out,
    input  wire [3:0]  spi_oe,
    output reg  [3:0]  spi_in,
    // spi on external memory port
    input  wire [3:0]  xm_spi_in,
    output reg  [3:0]  xm_spi_out,
    output reg  [3:0]  xm_spi_oe,
    // uart controller
    input  wire        uart_tx,
    output reg         uart_rx,
    // eeprom i2c master, bit 1 is pin 31
    input  wire [1:0]  i2c_drive_low,
    output reg  [1:0]  i2c_in,
    // dual-role id
    output reg         dual_role_id_pin,
    // effective interface enables
    output reg  [5:0]  if_active
);
    reg  [15:0] ctrl_reg;
    reg  [31:0] gpo_reg;
    reg  [31:0] dir_reg;
    reg  [31:0] rdata_next;
    reg         mapped_next;
    reg  [31:0] pin_o_next;
    reg  [31:0] pin_oe_next;
    reg  [31:0] claim_next;
    wire [31:0] cap;

    function [19:0] byte_addr;
        input [15:0] idx;
        begin
            byte_addr = {2'b00, idx, 2'b00};
        end
    endfunction

    // effective enables; host port wins over the three it excludes
    wire host_en = ctrl_reg[`GPSH_F_HOST_EN];
    wire fsp_en  = ctrl_reg[`GPSH_F_FSP_EN] & ~host_en;
    wire spi_en  = ctrl_reg[`GPSH_F_SPI_EN] & ~host_en;
    wire uart_en = ctrl_reg[`GPSH_F_UART_EN] & ~host_en;
    wire fsp_gp  = fsp_en & ~ctrl_reg[`GPSH_F_FSP_XM];
    wire fsp_xm  = fsp_en & ctrl_reg[`GPSH_F_FSP_XM];
    wire spi_gp  = spi_en & ~ctrl_reg[`GPSH_F_SPI_XM];
    wire spi_xm  = spi_en & ctrl_reg[`GPSH_F_SPI_XM];
    // alternate select shares pin 15 with cts, so fast serial keeps it
    wire ssi_alt = spi_gp & ctrl_reg[`GPSH_F_SSI_ALT] & ~fsp_gp;
    // never gated by other enables
    wire i2c_en  = ctrl_reg[`GPSH_F_I2C_EN];
    wire id_en   = ctrl_reg[`GPSH_F_ID_EN];

    wire setup     = psel & ~penable;
    wire access    = psel & penable & pready;
    wire hit_ctrl  = (paddr == byte_addr(`GPSH_CTRL_IDX));
    wire hit_out   = (paddr == byte_addr(`GPSH_OUT_IDX));
    wire hit_dir   = (paddr == byte_addr(`GPSH_DIR_IDX));
    wire hit_in    = (paddr == byte_addr(`GPSH_IN_IDX));
    wire hit_claim = (paddr == byte_addr(`GPSH_CLAIM_IDX));

    gpsh_pin_capture #(
        .WIDTH (32)
    ) u_capture (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (gpio_in),
        .cap_reg (cap)
    );

    // register read mux
    always @*
    begin
        mapped_next = 1'b1;
        if (hit_ctrl)
            rdata_next = {16'h0000, ctrl_reg};
        else if (hit_out)
            rdata_next = gpo_reg;
        else if (hit_dir)
            rdata_next = dir_reg;
        else if (hit_in)
            rdata_next = cap & `GPSH_PIN_VALID;
        else if (hit_claim)
            rdata_next = claim_next;
        else
        begin
            rdata_next  = 32'h00000000;
            mapped_next = 1'b0;
        end
    end

    // apb slave: one wait-free access phase, registers written at its edge
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata   <= 32'h00000000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            ctrl_reg <= `GPSH_CTRL_RST;
            gpo_reg  <= `GPSH_OUT_RST;
            dir_reg  <= `GPSH_PIN_VALID;
        end
        else
        begin
            pready  <= setup;
            prdata  <= setup ? rdata_next : 32'h00000000;
            pslverr <= setup & ~mapped_next;
            if (access & pwrite)
            begin
                if (hit_ctrl)
                    ctrl_reg <= pwdata[15:0] & `GPSH_CTRL_MASK;
                else if (hit_out)
                    gpo_reg <= pwdata & `GPSH_PIN_VALID;
                else if (hit_dir)
                    dir_reg <= pwdata & `GPSH_PIN_VALID;
            end
        end
    end

    // pin routing; later assignments take pins from plain gpio use
    always @*
    begin
        pin_o_next  = gpo_reg & `GPSH_PIN_VALID;
        pin_oe_next = dir_reg & `GPSH_PIN_VALID;
        claim_next  = 32'h00000000;
        if (host_en)
        begin
            pin_o_next[24:19]  = {host_int, 5'h00};
            pin_oe_next[24:19] = 6'h20;
            pin_o_next[15:0]   = host_data_bus_out;
            pin_oe_next[15:0]  = {16{host_data_bus_oe}};
            claim_next[24:19]  = 6'h3F;
            claim_next[15:0]   = 16'hFFFF;
        end
        if (fsp_gp)
        begin
            pin_o_next[15:12]  = {1'b0, fast_serial_port_rts, 1'b0,
                                  fast_serial_port_txd};
            pin_oe_next[15:12] = `GPSH_FSP_OE;
            claim_next[15:12]  = 4'hF;
        end
        if (spi_gp)
        begin
            pin_o_next[11:8]  = spi_out;
            pin_oe_next[11:8] = spi_oe;
            claim_next[11:8]  = 4'hF;
            if (ssi_alt)
            begin
                pin_o_next[`GPSH_PIN_SSI_STD]  = gpo_reg[`GPSH_PIN_SSI_STD];
                pin_oe_next[`GPSH_PIN_SSI_STD] = dir_reg[`GPSH_PIN_SSI_STD];
                claim_next[`GPSH_PIN_SSI_STD]  = 1'b0;
                pin_o_next[`GPSH_PIN_SSI_ALT]  = 1'b0;
                pin_oe_next[`GPSH_PIN_SSI_ALT] = 1'b0;
                claim_next[`GPSH_PIN_SSI_ALT]  = 1'b1;
            end
        end
        if (uart_en)
        begin
            pin_o_next[`GPSH_PIN_UART_TX]  = uart_tx;
            pin_oe_next[`GPSH_PIN_UART_TX] = 1'b1;
            pin_o_next[`GPSH_PIN_UART_RX]  = 1'b0;
            pin_oe_next[`GPSH_PIN_UART_RX] = 1'b0;
            claim_next[7:6]                = 2'h3;
        end
        if (i2c_en)
        begin
            // open drain: enable only while pulling low
            pin_o_next[31:30]  = 2'h0;
            pin_oe_next[31:30] = i2c_drive_low;
            claim_next[31:30]  = 2'h3;
        end
        if (id_en)
        begin
            pin_o_next[`GPSH_PIN_ID]  = 1'b0;
            pin_oe_next[`GPSH_PIN_ID] = 1'b0;
            claim_next[`GPSH_PIN_ID]  = 1'b1;
        end
    end

    gpsh_pin_drive #(
        .WIDTH  (32),
        .RST_OE (`GPSH_PIN_VALID)
    ) u_drive (
        .pclk     (pclk),
        .presetn  (presetn),
        .out_next (pin_o_next),
        .oe_next  (pin_oe_next),
        .out_reg  (gpio_out),
        .oe_reg   (gpio_oe)
    );

    // controller inputs: one flop straight from the routed source
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            host_data_bus_in     <= 16'h0000;
            host_ctl_in          <= `GPSH_HOST_IDLE;
            fast_serial_port_cts <= 1'b0;
            fast_serial_port_rxd <= 1'b1;
            xm_fsp_out           <= 2'h3;
            spi_in               <= `GPSH_SPI_IDLE;
            xm_spi_out           <= 4'h0;
            xm_spi_oe            <= 4'h0;
            uart_rx              <= 1'b1;
            i2c_in               <= 2'h3;
            dual_role_id_pin     <= 1'b1;
            if_active            <= 6'h00;
        end
        else
        begin
            if (host_en)
            begin
                host_data_bus_in <= gpio_in[15:0];
                host_ctl_in      <= gpio_in[23:19];
            end
            else
            begin
                host_data_bus_in <= 16'h0000;
                host_ctl_in      <= `GPSH_HOST_IDLE;
            end
            if (fsp_xm)
            begin
                fast_serial_port_cts <= xm_fsp_in[1];
                fast_serial_port_rxd <= xm_fsp_in[0];
            end
            else if (fsp_gp)
            begin
                fast_serial_port_cts <= gpio_in[15];
                fast_serial_port_rxd <= gpio_in[13];
            end
            else
            begin
                fast_serial_port_cts <= 1'b0;
                fast_serial_port_rxd <= 1'b1;
            end
            if (fsp_xm)
                xm_fsp_out <= {fast_serial_port_rts, fast_serial_port_txd};
            else
                xm_fsp_out <= 2'h3;
            if (spi_xm)
                spi_in <= xm_spi_in;
            else if (spi_gp)
                spi_in <= {gpio_in[11:10],
                           ssi_alt ? gpio_in[15] : gpio_in[9],
                           gpio_in[8]};
            else
                spi_in <= `GPSH_SPI_IDLE;
            if (spi_xm)
            begin
                xm_spi_out <= spi_out;
                xm_spi_oe  <= spi_oe;
            end
            else
            begin
                xm_spi_out <= 4'h0;
                xm_spi_oe  <= 4'h0;
            end
            uart_rx          <= uart_en ? gpio_in[`GPSH_PIN_UART_RX] : 1'b1;
            i2c_in           <= i2c_en ? gpio_in[31:30] : 2'h3;
            dual_role_id_pin <= id_en ? gpio_in[`GPSH_PIN_ID] : 1'b1;
            if_active        <= {id_en, i2c_en, uart_en, spi_en, fsp_en, host_en};
        end
    end
endmodule // gpsh_pin_share
`default_nettype wire

// file: dv/gpsh_monitor.sv
/* port checker of the gpio pin-sharing block.
   assumes it is bound to gpsh_pin_share. */
`timescale 1ns/1ps
`default_nettype none
module gpsh_monitor (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins and controllers
    input wire logic [31:0] gpio_in,
    input wire logic [31:0] gpio_out,
    input wire logic [31:0] gpio_oe,
    input wire logic        uart_tx,
    input wire logic        uart_rx,
    input wire logic [1:0]  i2c_drive_low,
    input wire logic        dual_role_id_pin,
    input wire logic [5:0]  if_active
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready held");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_host_excl: assert property (if_active[0] |-> if_active[3:1] == 3'h0)
        else $error("host port shares pins");
    chk_uart_route: assert property ($past(if_active[3]) && if_active[3] |->
        gpio_oe[7] && gpio_out[7] == $past(uart_tx) && uart_rx == $past(gpio_in[6]))
        else $error("uart misrouted");
    chk_i2c_open: assert property ($past(if_active[4]) && if_active[4] |->
        gpio_out[31:30] == 2'h0 && gpio_oe[31:30] == $past(i2c_drive_low))
        else $error("i2c pins misdriven");
    chk_id_follow: assert property ($past(if_active[5]) && if_active[5] |->
        dual_role_id_pin == $past(gpio_in[29]))
        else $error("id pin not one flop");
    chk_no_ghost: assert property ((gpio_oe & ~32'hE1F8FFFF) == 32'h0)
        else $error("absent pin driven");
endmodule // gpsh_monitor
bind gpsh_pin_share gpsh_monitor u_mon (.pclk, .presetn, .psel, .penable, .pready,
    .pslverr, .gpio_in, .gpio_out, .gpio_oe, .uart_tx, .uart_rx, .i2c_drive_low,
    .dual_role_id_pin, .if_active);
`default_nettype wire

// file: dv/gpsh_far_model.sv
/* board side of the pins: resolves each wire from the block's drive.
   assumes board holds the level of undriven pins, pull-ups included. */
`timescale 1ns/1ps
`default_nettype none
module gpsh_far_model (
    // block drive
    input wire logic [31:0] gpio_out,
    input wire logic [31:0] gpio_oe,
    // board levels
    input wire logic [31:0] board,
    output logic     [31:0] gpio_in
);
    // a driven pin shows the block's level, else the board's
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & board);
endmodule // gpsh_far_model
`default_nettype wire

// file: dv/test_gpsh_pin_share.sv
/* self-checking bench of the gpio pin-sharing block.
   assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
`default_nettype none
module test_gpsh_pin_share;
    localparam logic [19:0] CTRL = 20'h30018, OUT = 20'h30020, DIR = 20'h30024;
    localparam logic [19:0] IN = 20'h30028, CLAIM = 20'h3002C;
    localparam logic [31:0] B = 32'hE5A5A5A5;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, gpio_in, gpio_out, gpio_oe, board, src;
    logic [15:0] host_data_bus_in;
    logic [4:0]  host_ctl_in;
    logic [1:0]  xm_fsp_out, i2c_in;
    logic [3:0]  spi_in, xm_spi_out, xm_spi_oe;
    logic [5:0]  if_active;
    logic        fsp_cts, fsp_rxd, uart_rx, id_pin;
    int          n_errors, comparisons;

    gpsh_pin_share u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .gpio_in, .gpio_out, .gpio_oe, .host_int(src[0]),
        .host_data_bus_out(src[15:0]), .host_data_bus_oe(src[1]), .host_data_bus_in,
        .host_ctl_in, .fast_serial_port_rts(src[2]), .fast_serial_port_txd(src[3]),
        .fast_serial_port_cts(fsp_cts), .fast_serial_port_rxd(fsp_rxd),
        .xm_fsp_in(src[5:4]), .xm_fsp_out, .spi_out(src[9:6]), .spi_oe(src[13:10]),
        .spi_in, .xm_spi_in(src[17:14]), .xm_spi_out, .xm_spi_oe, .uart_tx(src[18]),
        .uart_rx, .i2c_drive_low(src[20:19]), .i2c_in, .dual_role_id_pin(id_pin),
        .if_active);
    gpsh_far_model u_far (.gpio_out, .gpio_oe, .board, .gpio_in);

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic acc(input logic w, input logic [19:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        if (!w)
            cmp("prdata", exp, prdata);
        cmp("pslverr", {31'h0, err}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle;
        repeat (3) @(posedge pclk);
        #1;
    endtask

    task automatic setc(input logic [31:0] v);
        acc(1'b1, CTRL, v, 32'h0, 1'b0);
        settle();
    endtask

    task automatic drive(input logic [31:0] s, input logic [31:0] b);
        @(posedge pclk);
        src <= s;
        board <= b;
    endtask

    // pin levels seen with DIR 0F0F and OUT 000F
    function automatic logic [31:0] exp_in(input logic [31:0] b);
        return (32'hF | (b & ~32'h0F0F)) & 32'hE1F8FFFF;
    endfunction

    task automatic tend(input string name);
        $display("test %s done", name);
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #200us;
        n_errors++;
        summarize();
    end

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 20'h0;
        pwdata = 32'h0;
        src = 32'h0;
        board = B;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        cmp("gpio_oe", 32'hE1F8FFFF, gpio_oe);
        cmp("gpio_out", 32'h0, gpio_out);
        acc(1'b0, CTRL, 32'h0, 32'h0, 1'b0);
        acc(1'b0, DIR, 32'h0, 32'hE1F8FFFF, 1'b0);
        acc(1'b0, 20'h30030, 32'h0, 32'h0, 1'b1);
        tend("reset");
        acc(1'b1, DIR, 32'h0F0F, 32'h0, 1'b0);
        acc(1'b1, OUT, 32'h000F, 32'h0, 1'b0);
        settle();
        cmp("gpio_oe", 32'h0F0F, gpio_oe);
        cmp("gpio_out", 32'hF, gpio_out & 32'h0F0F);
        acc(1'b0, IN, 32'h0, exp_in(B), 1'b0);
        drive(32'h0, ~B);
        acc(1'b0, IN, 32'h0, exp_in(~B), 1'b0);
        drive(32'h40000, B);
        acc(1'b1, DIR, 32'h0, 32'h0, 1'b0);
        tend("gpio");
        setc(32'h8);
        cmp("uart tx", 32'h3, {30'h0, gpio_oe[7], gpio_out[7]});
        cmp("uart_rx", 32'h0, {31'h0, uart_rx});
        acc(1'b0, CLAIM, 32'h0, 32'hC0, 1'b0);
        tend("uart");
        drive(32'h28140, B);
        setc(32'h4);
        cmp("spi_in", 32'h5, {28'h0, spi_in});
        acc(1'b0, CLAIM, 32'h0, 32'hF00, 1'b0);
        setc(32'h24);
        cmp("spi_in alt", 32'h7, {28'h0, spi_in});
        acc(1'b0, CLAIM, 32'h0, 32'h8D00, 1'b0);
        drive(32'h2A940, B);
        setc(32'h14);
        cmp("spi ext", 32'hA5A, {20'h0, xm_spi_oe, xm_spi_out, spi_in});
        cmp("spi ext pins", 32'h0, gpio_oe & 32'hF00);
        acc(1'b0, CLAIM, 32'h0, 32'h0, 1'b0);
        tend("spi");
        drive(32'h24, B);
        setc(32'h2);
        cmp("fsp gpio", 32'hB, {28'h0, gpio_out[14], gpio_out[12], fsp_cts, fsp_rxd});
        setc(32'h42);
        cmp("fsp ext", 32'hA, {28'h0, xm_fsp_out, fsp_cts, fsp_rxd});
        tend("fast serial");
        setc(32'hF);
        cmp("if_active", 32'h1, {26'h0, if_active});
        cmp("host in", 32'h14A5A5, {11'h0, host_ctl_in, host_data_bus_in});
        acc(1'b0, CLAIM, 32'h0, 32'h01F8FFFF, 1'b0);
        drive(32'h0000A5C3, B);
        settle();
        cmp("host oe", 32'h0100FFFF, gpio_oe & 32'h01F8FFFF);
        cmp("host out", 32'h0100A5C3, gpio_out & 32'h01F8FFFF);
        tend("host");
        drive(32'h100000, B);
        setc(32'h18F);
        cmp("if_active", 32'h31, {26'h0, if_active});
        cmp("i2c id", 32'h43, {25'h0, gpio_oe[31:30], gpio_out[31:30], i2c_in, id_pin});
        acc(1'b0, CLAIM, 32'h0, 32'hE1F8FFFF, 1'b0);
        tend("i2c id");
        @(posedge pclk);
        presetn <= 1'b0;
        settle();
        cmp("if_active in reset", 32'h0, {26'h0, if_active});
        @(posedge pclk);
        presetn <= 1'b1;
        settle();
        cmp("gpio_oe after reset", 32'hE1F8FFFF, gpio_oe);
        acc(1'b0, CTRL, 32'h0, 32'h0, 1'b0);
        tend("reset again");
        summarize();
    end
endmodule // test_gpsh_pin_share
`default_nettype wire
